// >>> capture_compare_timer16_tb_top.sv
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module capture_compare_timer16_tb_top
    import cct_pkg::*;
;
    logic clk, rstn, cpuWrite, cpuRead, cpuWide;
    logic [15:0] cpuAddr, cpuWdata, cpuRdata;
    logic oscDivideSelect, watchTimerOut, subClock;
    logic countInputPrimary, countInputSecondary;
    logic timerOutputPin, progClockOut, matchIrqA, matchIrqB;
    logic extIrqFlagZero;
    int failCount = 0;
    int samplesChecked = 0;
    int irqCount = 0;
    bit rdSeen = 1'b0;
    logic [15:0] expQ[$];
    logic [15:0] addrQ[$];
    logic [15:0] aVals[3];
    logic [31:0] seed;
    int n;

    cct_timer DUT (.clk(clk), .rstn(rstn), .cpuAddr(cpuAddr),
        .cpuWrite(cpuWrite), .cpuRead(cpuRead), .cpuWide(cpuWide),
        .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
        .oscDivideSelect(oscDivideSelect), .watchTimerOut(watchTimerOut),
        .subClock(subClock), .countInputPrimary(countInputPrimary),
        .countInputSecondary(countInputSecondary),
        .timerOutputPin(timerOutputPin), .progClockOut(progClockOut),
        .matchIrqA(matchIrqA), .matchIrqB(matchIrqB),
        .extIrqFlagZero(extIrqFlagZero));
    cct_pin_partner partner (.clk(clk),
        .countInputPrimary(countInputPrimary),
        .countInputSecondary(countInputSecondary),
        .timerOutputPin(timerOutputPin));

    // 100 MHz clock
    always #5 clk = ~clk;

    // Fixed-seed pseudo-random source
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samplesChecked,
            failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe; an edge always passes before the next one
    task automatic wr(input logic [15:0] a, input logic [15:0] d,
        input logic w);
        @(posedge clk);
        cpuAddr <= a;
        cpuWdata <= d;
        cpuWide <= w;
        cpuWrite <= 1'b1;
        @(posedge clk);
        cpuWrite <= 1'b0;
    endtask

    // Read strobe; the expectation goes to the queue for the monitor
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        cpuAddr <= a;
        cpuWide <= 1'b1;
        cpuRead <= 1'b1;
        addrQ.push_back(a);
        expQ.push_back(e);
        @(posedge clk);
        cpuRead <= 1'b0;
    endtask

    // Bounded wait for a match pulse, then the cycles to the next one
    task automatic measureGap(input bit useB, input int expGap);
        n = 0;
        while ((useB ? matchIrqB : matchIrqA) !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((useB ? matchIrqB : matchIrqA) !== 1'b1 && n < 1000);
        check(useB ? "gap b" : "gap a", expGap[15:0], n[15:0]);
        if (n >= 1000) begin
            tally_and_finish();
        end
    endtask

    // Monitor: read data is compared the cycle after the strobe
    always @(posedge clk) begin
        if (rdSeen) begin
            if (expQ.size() == 0) begin
                check("read queue", 16'h0000, 16'hFFFF);
            end else begin
                check($sformatf("read %h", addrQ.pop_front()),
                    expQ.pop_front(), cpuRdata);
            end
        end
        rdSeen = cpuRead;
        if (extIrqFlagZero === 1'b1) begin
            irqCount++;
        end
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        {cpuWrite, cpuRead, cpuWide} = 3'h0;
        cpuAddr = 16'h0000;
        cpuWdata = 16'h0000;
        oscDivideSelect = 1'b1;
        watchTimerOut = 1'b0;
        subClock = 1'b0;
        seed = 32'hE19DF4A2;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        // Values after reset, and an unmapped place
        rd(ADDR_CLOCK_SELECT, 16'h0000);
        rd(ADDR_COUNT_VALUE, 16'h0000);
        rd(ADDR_CAPCOMP_CTRL, 16'h0004);
        rd(ADDR_MODE_CONTROL, 16'h0000);
        rd(16'hFF02, 16'h0000);
        // Interval timing on the system clock, both registers compare
        wr(ADDR_CLOCK_SELECT, 16'h0010, 1'b0);
        rd(ADDR_CLOCK_SELECT, 16'h0010);
        wr(ADDR_CAPCOMP_CTRL, 16'h0000, 1'b0);
        seed = lfsrNext(seed);
        aVals = '{16'h0001, 16'h0002 + {8'h00, seed[7:0]}, 16'h0007};
        foreach (aVals[i]) begin
            wr(ADDR_MODE_CONTROL, 16'h0000, 1'b0);
            wr(ADDR_CAPCOMP_A, aVals[i], 1'b1);
            wr(ADDR_CAPCOMP_B, aVals[i] >> 1, 1'b1);
            wr(ADDR_MODE_CONTROL, 16'h000C, 1'b0);
            measureGap(1'b0, int'(aVals[i]) + 1);
            measureGap(1'b1, int'(aVals[i]) + 1);
        end
        // A narrow write to a capture/compare register is dropped
        wr(ADDR_CAPCOMP_A, 16'h5A5A, 1'b0);
        rd(ADDR_CAPCOMP_A, 16'h0007);
        // Event counting with capture on the primary pin
        wr(ADDR_MODE_CONTROL, 16'h0000, 1'b0);
        wr(ADDR_CLOCK_SELECT, 16'h0000, 1'b0);
        wr(ADDR_EDGE_MODE, 16'h0004, 1'b0);
        wr(ADDR_CAPCOMP_CTRL, 16'h0007, 1'b0);
        wr(ADDR_MODE_CONTROL, 16'h0004, 1'b0);
        partner.drivePin(1'b1);
        rd(ADDR_CAPCOMP_A, 16'h0007);
        rd(ADDR_COUNT_VALUE, 16'h0001);
        partner.drivePin(1'b0);
        rd(ADDR_CAPCOMP_A, 16'h0001);
        seed = lfsrNext(seed);
        n = 1 + int'(seed[2:0]);
        partner.pulses(n);
        rd(ADDR_COUNT_VALUE, 16'(n + 1));
        rd(ADDR_CAPCOMP_B, 16'(n + 1));
        rd(ADDR_CAPCOMP_A, 16'(n + 1));
        // Valid edge while B is read: capture skipped, request still raised
        fork
            partner.drivePin(1'b1);
            rd(ADDR_CAPCOMP_B, 16'(n + 1));
        join
        rd(ADDR_CAPCOMP_B, 16'(n + 1));
        partner.drivePin(1'b0);
        check("edge irq count", 16'(n + 2), 16'(irqCount));
        // Both pin edges count but give no capture of A
        wr(ADDR_MODE_CONTROL, 16'h0000, 1'b0);
        wr(ADDR_EDGE_MODE, 16'h000C, 1'b0);
        wr(ADDR_MODE_CONTROL, 16'h0004, 1'b0);
        partner.pulses(1);
        rd(ADDR_COUNT_VALUE, 16'h0002);
        rd(ADDR_CAPCOMP_A, 16'(n + 2));
        // PWM stepped by pin edges: output high while count is below 8
        wr(ADDR_MODE_CONTROL, 16'h0000, 1'b0);
        wr(ADDR_EDGE_MODE, 16'h0004, 1'b0);
        wr(ADDR_CAPCOMP_CTRL, 16'h0004, 1'b0);
        wr(ADDR_OUTPUT_CTRL, 16'h0001, 1'b0);
        wr(ADDR_MODE_CONTROL, 16'h0002, 1'b0);
        wr(ADDR_CAPCOMP_A, 16'h0008, 1'b1);
        for (int k = 1; k <= 9; k++) begin
            partner.pulses(1);
            check("pwm pin", 16'(k < 8), {15'h0000, timerOutputPin});
        end
        // B kept capturing on each rise while PWM ran; last rise at 8
        rd(ADDR_CAPCOMP_B, 16'h0008);
        // Clear on A at all ones wraps through zero and flags overflow
        wr(ADDR_MODE_CONTROL, 16'h0000, 1'b0);
        wr(ADDR_OUTPUT_CTRL, 16'h0000, 1'b0);
        wr(ADDR_CLOCK_SELECT, 16'h0010, 1'b0);
        wr(ADDR_CAPCOMP_A, 16'hFFFF, 1'b1);
        wr(ADDR_MODE_CONTROL, 16'h000C, 1'b0);
        repeat (65536 + 40) @(posedge clk);
        rd(ADDR_MODE_CONTROL, 16'h000D);
        // Subclock on the clock output; a secondary edge captures A
        wr(ADDR_MODE_CONTROL, 16'h0000, 1'b0);
        wr(ADDR_CLOCK_SELECT, 16'h0080, 1'b0);
        wr(ADDR_CAPCOMP_CTRL, 16'h0001, 1'b0);
        wr(ADDR_EDGE_MODE, 16'h0010, 1'b0);
        wr(ADDR_MODE_CONTROL, 16'h0004, 1'b0);
        subClock <= 1'b1;
        partner.driveSec(1'b1);
        check("clock out", 16'h0001, {15'h0000, progClockOut});
        rd(ADDR_CAPCOMP_A, 16'h0000);
        repeat (3) @(posedge clk);
        check("reads left", 16'h0000, 16'(expQ.size()));
        tally_and_finish();
    end
endmodule

// >>> cct_edge_det.sv
// Edge detector for one pin, with selectable valid edge
`timescale 1ns/1ps
module cct_edge_det
    import cct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pin and detected edges
    cct_edge_if.det edge_io
);

    typedef struct packed {
        logic prev;
    } cct_edge_s;

    cct_edge_s s;
    cct_edge_s next_s;

    // Remember last pin level
    always_comb begin
        next_s = s;
        next_s.prev = edge_io.pin;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Edges seen against the previous level; code 10 gives no edge
    always_comb begin
        edge_io.rise = edge_io.pin & ~s.prev;
        edge_io.fall = ~edge_io.pin & s.prev;
        case (edge_io.sel)
            EDGE_FALL: edge_io.valid = edge_io.fall;
            EDGE_RISE: edge_io.valid = edge_io.rise;
            EDGE_BOTH: edge_io.valid = edge_io.rise | edge_io.fall;
            default: edge_io.valid = 1'b0;
        endcase
    end

endmodule

// >>> cct_edge_if.sv
// Carrier between the timer core and its pin edge detectors
`timescale 1ns/1ps
interface cct_edge_if;
    logic pin;
    logic [1:0] sel;
    logic rise;
    logic fall;
    logic valid;

    modport det (input pin, input sel, output rise, output fall,
        output valid);
    modport user (output pin, output sel, input rise, input fall,
        input valid);
endinterface

// >>> cct_pin_partner.sv
// Pin-side partner: pulse source on the count inputs, load on the output
`timescale 1ns/1ps
module cct_pin_partner (
    // Clock
    input wire logic clk,
    // Pins
    output logic countInputPrimary,
    output logic countInputSecondary,
    input wire logic timerOutputPin
);
    // Pins idle low; the secondary input only carries single edges
    initial begin
        countInputPrimary = 1'b0;
        countInputSecondary = 1'b0;
    end
    // Level held four cycles so the edge detector sees every edge
    task automatic drivePin(input logic v);
        @(posedge clk);
        countInputPrimary <= v;
        repeat (4) @(posedge clk);
    endtask
    // Whole pulses, edges spaced wider than every other cycle
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            drivePin(1'b1);
            drivePin(1'b0);
        end
    endtask
    // Secondary level, held as long as the primary one
    task automatic driveSec(input logic v);
        @(posedge clk);
        countInputSecondary <= v;
        repeat (4) @(posedge clk);
    endtask
endmodule

// >>> cct_pkg.sv
// Constants, addresses and field positions of the capture/compare timer
package cct_pkg;

    // Register addresses on the CPU memory bus
    localparam logic [15:0] ADDR_CLOCK_SELECT = 16'hFF40;
    localparam logic [15:0] ADDR_MODE_CONTROL = 16'hFF48;
    localparam logic [15:0] ADDR_CAPCOMP_CTRL = 16'hFF4C;
    localparam logic [15:0] ADDR_OUTPUT_CTRL = 16'hFF4E;
    localparam logic [15:0] ADDR_EDGE_MODE = 16'hFFEC;
    localparam logic [15:0] ADDR_COUNT_VALUE = 16'hFF10;
    localparam logic [15:0] ADDR_CAPCOMP_A = 16'hFF12;
    localparam logic [15:0] ADDR_CAPCOMP_B = 16'hFF14;

    // Values after reset, and the all-ones count
    localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
    localparam logic [2:0] CAPCOMP_CTRL_RESET = 3'h4;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] CAPCOMP_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

    // Field positions
    localparam int CLK_OUT_ENABLE_BIT = 7;
    localparam int CAPCOMP_A_FUNC_BIT = 0;
    localparam int CAPCOMP_A_TRIG_BIT = 1;
    localparam int CAPCOMP_B_FUNC_BIT = 2;
    localparam int OVERFLOW_BIT = 0;
    localparam int OUT_ENABLE_BIT = 0;
    localparam int OUT_ACTIVE_BIT = 1;
    localparam int OUT_RESET_BIT = 2;
    localparam int OUT_SET_BIT = 3;
    localparam int OUT_TOGGLE_B_BIT = 4;
    localparam int ONE_SHOT_EN_BIT = 5;
    localparam int ONE_SHOT_TRIG_BIT = 6;
    localparam int EDGE_PRI_LSB = 2;
    localparam int EDGE_SEC_LSB = 4;

    // Operating modes held in the three mode bits
    localparam logic [2:0] MODE_STOP = 3'h0;
    localparam logic [2:0] MODE_PWM = 3'h1;

    // Count clock sources
    localparam logic [2:0] CNT_SRC_PIN = 3'h0;
    localparam logic [2:0] CNT_SRC_FX = 3'h1;
    localparam logic [2:0] CNT_SRC_FXX = 3'h2;
    localparam logic [2:0] CNT_SRC_FXX_2 = 3'h3;
    localparam logic [2:0] CNT_SRC_FXX_4 = 3'h4;
    localparam logic [2:0] CNT_SRC_WATCH = 3'h7;

    // Clock output sources
    localparam logic [3:0] CLKOUT_SRC_SUB = 4'h0;
    localparam logic [3:0] CLKOUT_SRC_FIRST = 4'h5;
    localparam logic [3:0] CLKOUT_SRC_LAST = 4'hC;

    // Pin edge selection codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage

// >>> cct_timer.sv
// 16-bit timer/event counter with two capture/compare registers
// Functional notes
// - Control bit 0 picks capture or compare A
// - Compare A equals count: raise match A
// - Capture A triggered by primary or secondary edge
// - Primary capture A edge inverts pin edge select
// - Value below count: wrap and continue
// - Control bit 2 picks capture or compare B
// - Compare B equals count: raise match B
// - Capture B uses primary valid edge only
// - Edge during B read: skip, still flag
// - Counter clears at reset, counts pulses
// - Count read goes through register B
// - Capture/compare registers written by 16-bit only
// - Clock select resets zero, picks clock output too
// - Interval from one to 65536 count periods
// - PWM output with 14-bit resolution
// - PWM and width capture run together
// - Count clock: pin, divided clock, watch
// - Event mode counts each valid pulse
// - Non-zero mode starts, zero stops clears
// - Clear-on-A with all ones sets overflow
`timescale 1ns/1ps
module cct_timer
    import cct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // CPU memory bus
    input wire logic [15:0] cpuAddr,
    input wire logic cpuWrite,
    input wire logic cpuRead,
    input wire logic cpuWide,
    input wire logic [15:0] cpuWdata,
    output logic [15:0] cpuRdata,
    // Clock inputs from the rest of the chip
    input wire logic oscDivideSelect,
    input wire logic watchTimerOut,
    input wire logic subClock,
    // Pins
    input wire logic countInputPrimary,
    input wire logic countInputSecondary,
    output logic timerOutputPin,
    output logic progClockOut,
    // Interrupt request pulses
    output logic matchIrqA,
    output logic matchIrqB,
    output logic extIrqFlagZero
);

    typedef struct packed {
        logic [7:0] clkSel;
        logic [2:0] mode;
        logic ovf;
        logic [2:0] ccCtrl;
        logic outEnable;
        logic outActive;
        logic toggleB;
        logic oneShotEn;
        logic oneShotArmed;
        logic [1:0] edgePri;
        logic [1:0] edgeSec;
        logic [15:0] ccA;
        logic [15:0] ccB;
        logic [15:0] cnt;
        logic [7:0] pre;
        logic level;
        logic pin;
        logic clkOut;
        logic matchA;
        logic matchB;
        logic extIrq;
        logic [15:0] rdata;
    } cct_state_s;

    cct_state_s s;
    cct_state_s next_s;

    cct_edge_if priIf ();
    cct_edge_if secIf ();
    cct_edge_if watchIf ();

    // Edge detectors for both count inputs and the watch timer
    assign priIf.pin = countInputPrimary;
    assign priIf.sel = s.edgePri;
    assign secIf.pin = countInputSecondary;
    assign secIf.sel = s.edgeSec;
    assign watchIf.pin = watchTimerOut;
    assign watchIf.sel = EDGE_RISE;

    cct_edge_det uPri (
        .clk(clk),
        .rstn(rstn),
        .edge_io(priIf.det)
    );

    cct_edge_det uSec (
        .clk(clk),
        .rstn(rstn),
        .edge_io(secIf.det)
    );

    cct_edge_det uWatch (
        .clk(clk),
        .rstn(rstn),
        .edge_io(watchIf.det)
    );

    logic running;
    logic clearOnEdge;
    logic clearOnMatchA;
    logic toggleOnEdge;
    logic [1:0] divExp;
    logic [7:0] divMask;
    logic tick;
    logic trigA;
    logic readingB;
    logic [3:0] clkOutExp;

    // Mode decode from the stored mode bits
    always_comb begin
        running = (s.mode != MODE_STOP);
        clearOnEdge = (s.mode[2:1] == 2'h2);
        clearOnMatchA = (s.mode[2:1] == 2'h3);
        toggleOnEdge = s.mode[0] && (s.mode != MODE_PWM);
    end

    // Count clock select; prescaler pulses stand in for slower clocks
    always_comb begin
        divExp = 2'h0;
        tick = 1'b0;
        case (s.clkSel[6:4])
            CNT_SRC_FX: divExp = 2'h0;
            CNT_SRC_FXX: divExp = oscDivideSelect ? 2'h0 : 2'h1;
            CNT_SRC_FXX_2: divExp = oscDivideSelect ? 2'h1 : 2'h2;
            CNT_SRC_FXX_4: divExp = oscDivideSelect ? 2'h2 : 2'h3;
            default: divExp = 2'h0;
        endcase
        divMask = 8'(({8'h00, 8'h01} << divExp) - 16'h0001);
        case (s.clkSel[6:4])
            CNT_SRC_PIN: tick = priIf.valid;
            CNT_SRC_FX, CNT_SRC_FXX, CNT_SRC_FXX_2, CNT_SRC_FXX_4:
                tick = ((s.pre & divMask) == divMask);
            CNT_SRC_WATCH: tick = watchIf.valid;
            default: tick = 1'b0;
        endcase
    end

    // Capture triggers; pin edge 11 leaves register A without trigger
    always_comb begin
        if (s.ccCtrl[CAPCOMP_A_TRIG_BIT]) begin
            case (s.edgePri)
                EDGE_FALL: trigA = priIf.rise;
                EDGE_RISE: trigA = priIf.fall;
                default: trigA = 1'b0;
            endcase
        end else begin
            trigA = secIf.valid;
        end
        readingB = cpuRead && (cpuAddr == ADDR_CAPCOMP_B);
    end

    // Clock output exponent; divide by fx/fxx scaling from the mode bit
    always_comb begin
        clkOutExp = 4'(s.clkSel[3:0] - CLKOUT_SRC_FIRST)
            + (oscDivideSelect ? 4'h0 : 4'h1);
    end

    // Next state: bus access, counting, compare, capture and outputs
    always_comb begin
        next_s = s;
        next_s.matchA = 1'b0;
        next_s.matchB = 1'b0;
        next_s.extIrq = 1'b0;
        next_s.pre = s.pre + 8'h01;
        // Register writes
        if (cpuWrite) begin
            case (cpuAddr)
                ADDR_CLOCK_SELECT: next_s.clkSel = cpuWdata[7:0];
                ADDR_MODE_CONTROL: begin
                    next_s.mode = cpuWdata[3:1];
                    next_s.ovf = cpuWdata[OVERFLOW_BIT];
                end
                ADDR_CAPCOMP_CTRL: next_s.ccCtrl = cpuWdata[2:0];
                ADDR_OUTPUT_CTRL: begin
                    next_s.outEnable = cpuWdata[OUT_ENABLE_BIT];
                    next_s.outActive = cpuWdata[OUT_ACTIVE_BIT];
                    next_s.toggleB = cpuWdata[OUT_TOGGLE_B_BIT];
                    next_s.oneShotEn = cpuWdata[ONE_SHOT_EN_BIT];
                    // Set and reset act once and are not stored
                    if (cpuWdata[OUT_SET_BIT] & ~cpuWdata[OUT_RESET_BIT]) begin
                        next_s.level = 1'b1;
                    end else if (cpuWdata[OUT_RESET_BIT]
                        && !cpuWdata[OUT_SET_BIT]) begin
                        next_s.level = 1'b0;
                    end
                    if (cpuWdata[ONE_SHOT_TRIG_BIT]) begin
                        next_s.oneShotArmed = 1'b1;
                    end
                end
                ADDR_EDGE_MODE: begin
                    next_s.edgePri = cpuWdata[EDGE_PRI_LSB +: 2];
                    next_s.edgeSec = cpuWdata[EDGE_SEC_LSB +: 2];
                end
                ADDR_CAPCOMP_A: if (cpuWide) next_s.ccA = cpuWdata;
                ADDR_CAPCOMP_B: if (cpuWide) next_s.ccB = cpuWdata;
                default: ;
            endcase
        end
        // Compare matches seen as the count steps
        if (running && tick && !s.ccCtrl[CAPCOMP_A_FUNC_BIT]
            && s.cnt == s.ccA) begin
            next_s.matchA = 1'b1;
        end
        if (running && tick && !s.ccCtrl[CAPCOMP_B_FUNC_BIT]
            && s.cnt == s.ccB) begin
            next_s.matchB = 1'b1;
        end
        // Counter; a value below the count lets it wrap through zero
        if (next_s.mode == MODE_STOP) begin
            next_s.cnt = COUNT_RESET;
        end else if (running && clearOnEdge && priIf.valid) begin
            next_s.cnt = COUNT_RESET;
        end else if (running && tick) begin
            if (clearOnMatchA && s.cnt == s.ccA) begin
                next_s.cnt = COUNT_RESET;
            end else begin
                next_s.cnt = s.cnt + 16'h0001;
            end
            if (s.cnt == COUNT_ALL_ONES) begin
                next_s.ovf = 1'b1;
            end
        end
        // Primary valid edge always raises the external request
        next_s.extIrq = priIf.valid;
        // Captures take the count of the detecting cycle
        if (s.ccCtrl[CAPCOMP_A_FUNC_BIT] && trigA) begin
            next_s.ccA = s.cnt;
        end
        if (s.ccCtrl[CAPCOMP_B_FUNC_BIT] && priIf.valid && !readingB) begin
            next_s.ccB = s.cnt;
        end
        // Register reads; the count is fetched through register B
        if (cpuRead) begin
            case (cpuAddr)
                ADDR_CLOCK_SELECT: next_s.rdata = {8'h00, s.clkSel};
                ADDR_MODE_CONTROL: next_s.rdata = {12'h000, s.mode, s.ovf};
                ADDR_CAPCOMP_CTRL: next_s.rdata = {13'h0000, s.ccCtrl};
                ADDR_OUTPUT_CTRL: next_s.rdata = {10'h000, s.oneShotEn,
                    s.toggleB, 2'h0, s.outActive, s.outEnable};
                ADDR_EDGE_MODE: next_s.rdata = {10'h000, s.edgeSec,
                    s.edgePri, 2'h0};
                ADDR_CAPCOMP_A: next_s.rdata = s.ccA;
                ADDR_CAPCOMP_B: next_s.rdata = s.ccB;
                ADDR_COUNT_VALUE: begin
                    next_s.rdata = s.cnt;
                    next_s.ccB = s.cnt;
                end
                default: next_s.rdata = 16'h0000;
            endcase
        end
        // Timer flip-flop; one-shot waits for its trigger
        if (s.oneShotEn) begin
            if (s.oneShotArmed && next_s.matchB) begin
                next_s.level = 1'b1;
            end else if (s.oneShotArmed && next_s.matchA) begin
                next_s.level = 1'b0;
                next_s.oneShotArmed = 1'b0;
            end
        end else if ((next_s.matchA && s.outActive)
            ^ (next_s.matchB && s.toggleB)
            ^ (toggleOnEdge && priIf.valid)) begin
            next_s.level = ~s.level;
        end
        // PWM compares the upper 14 bits; captures keep working alongside
        if (next_s.mode == MODE_PWM) begin
            next_s.level = (next_s.cnt[15:2] < next_s.ccA[15:2])
                ^ next_s.outActive;
        end
        next_s.pin = next_s.outEnable & next_s.level;
        // Clock output from the prescaler; code 0 passes the subclock
        if (!s.clkSel[CLK_OUT_ENABLE_BIT]) begin
            next_s.clkOut = 1'b0;
        end else if (s.clkSel[3:0] == CLKOUT_SRC_SUB) begin
            next_s.clkOut = subClock;
        end else if (s.clkSel[3:0] >= CLKOUT_SRC_FIRST
            && s.clkSel[3:0] <= CLKOUT_SRC_LAST) begin
            next_s.clkOut = (clkOutExp == 4'h0) ? s.pre[0]
                : s.pre[3'(clkOutExp - 4'h1)];
        end else begin
            next_s.clkOut = 1'b0;
        end
    end

    // State register; capture/compare contents are unspecified, zeroed here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.clkSel <= CLOCK_SELECT_RESET;
            s.ccCtrl <= CAPCOMP_CTRL_RESET;
            s.cnt <= COUNT_RESET;
            s.ccA <= CAPCOMP_RESET;
            s.ccB <= CAPCOMP_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs all come from the state register
    assign cpuRdata = s.rdata;
    assign timerOutputPin = s.pin;
    assign progClockOut = s.clkOut;
    assign matchIrqA = s.matchA;
    assign matchIrqB = s.matchB;
    assign extIrqFlagZero = s.extIrq;

    // Checks on counter, captures and outputs
    a_stop_clears_count: assert property (@(posedge clk) disable iff (!rstn)
        s.mode == MODE_STOP |-> s.cnt == COUNT_RESET)
        else $error("count not zero while stopped");

    a_match_a_irq: assert property (@(posedge clk) disable iff (!rstn)
        running && tick && !s.ccCtrl[0] && s.cnt == s.ccA
        |=> matchIrqA)
        else $error("match A request missing");

    a_match_b_irq: assert property (@(posedge clk) disable iff (!rstn)
        running && tick && !s.ccCtrl[2] && s.cnt == s.ccB
        |=> matchIrqB)
        else $error("match B request missing");

    a_capture_b_skip: assert property (@(posedge clk) disable iff (!rstn)
        priIf.valid && s.ccCtrl[2] && readingB && !cpuWrite
        |=> s.ccB == $past(s.ccB) && extIrqFlagZero)
        else $error("capture B not skipped during read");

    a_count_read_path: assert property (@(posedge clk) disable iff (!rstn)
        cpuRead && cpuAddr == ADDR_COUNT_VALUE
        |=> s.ccB == $past(s.cnt) && cpuRdata == $past(s.cnt))
        else $error("count read not routed through B");

    a_capture_a_latch: assert property (@(posedge clk) disable iff (!rstn)
        s.ccCtrl[0] && trigA |=> s.ccA == $past(s.cnt))
        else $error("capture A missed the count");

    a_narrow_write_a: assert property (@(posedge clk) disable iff (!rstn)
        cpuWrite && !cpuWide && cpuAddr == ADDR_CAPCOMP_A && !s.ccCtrl[0]
        |=> s.ccA == $past(s.ccA))
        else $error("byte write changed register A");

    a_overflow_wrap: assert property (@(posedge clk) disable iff (!rstn)
        running && tick && s.cnt == COUNT_ALL_ONES && !cpuWrite
        |=> s.ovf && s.cnt == COUNT_RESET)
        else $error("overflow flag not set on wrap");

    a_event_count: assert property (@(posedge clk) disable iff (!rstn)
        s.clkSel[6:4] == CNT_SRC_PIN && s.mode[2:1] == 2'h1
        && priIf.valid && !cpuWrite
        |=> s.cnt == 16'($past(s.cnt) + 16'h0001))
        else $error("event pulse not counted");

    a_pwm_level: assert property (@(posedge clk) disable iff (!rstn)
        s.mode == MODE_PWM |-> timerOutputPin == (s.outEnable
        & ((s.cnt[15:2] < s.ccA[15:2]) ^ s.outActive)))
        else $error("PWM output level wrong");

    c_match_a: cover property (@(posedge clk) disable iff (!rstn)
        matchIrqA);
    c_capture_b: cover property (@(posedge clk) disable iff (!rstn)
        s.ccCtrl[2] && priIf.valid && !readingB);
    c_overflow: cover property (@(posedge clk) disable iff (!rstn)
        $rose(s.ovf));
    c_pwm_capture: cover property (@(posedge clk) disable iff (!rstn)
        s.mode == MODE_PWM && s.ccCtrl[2] && priIf.valid);

endmodule
